// >>> rtl/sia_pkg.sv
// Package of register offsets, field positions and codes for the hub bank.
package sia_pkg;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_PORT_SEL   = 8'h4c;
   localparam logic [7:0] ADDR_RISE_MASK  = 8'h7e;
   localparam logic [7:0] ADDR_FALL_MASK  = 8'h7f;
   localparam logic [7:0] ADDR_RISE_LATCH = 8'h80;
   localparam logic [7:0] ADDR_FALL_LATCH = 8'h81;
   localparam logic [7:0] ADDR_REF_CLOCK  = 8'ha5;
   localparam logic [7:0] ADDR_IND_CTL    = 8'hb0;
   localparam logic [7:0] ADDR_IND_OFFSET = 8'hb1;
   localparam logic [7:0] ADDR_IND_DATA   = 8'hb2;

   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int         CTL_PREFETCH_BIT = 0;
   localparam int         CTL_AUTOINC_BIT  = 1;
   localparam int         CTL_SEL_LSB      = 2;
   localparam int         CTL_SEL_MSB      = 5;
   localparam logic [7:0] RST_BYTE         = 8'h00;
   localparam logic [7:0] CTL_WRITE_MASK   = 8'h3f;
   localparam logic [1:0] PORT_SEL_MASK    = 2'h3;

   // ------------------------------------------------------------------
   // Indirect target codes
   // ------------------------------------------------------------------
   localparam logic [3:0] TGT_PATGEN    = 4'h0;
   localparam logic [3:0] TGT_PORT0     = 4'h1;
   localparam logic [3:0] TGT_PORT1     = 4'h2;
   localparam logic [3:0] TGT_SHARED    = 4'h5;
   localparam logic [3:0] TGT_BOTH_PORT = 4'h6;
   localparam logic [3:0] TGT_CSI       = 4'h7;

   // One-hot target strobe lanes.
   localparam int         LANE_PATGEN = 0;
   localparam int         LANE_PORT0  = 1;
   localparam int         LANE_PORT1  = 2;
   localparam int         LANE_SHARED = 3;
   localparam int         LANE_CSI    = 4;
   localparam int         NUM_LANES   = 5;

endpackage

// >>> rtl/sia_edge_latch.sv
// One receive port's sensor edge detector with sticky rise and fall latches.
module sia_edge_latch #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   // Sensor status and masks
   input  wire logic [WIDTH-1:0] status_i,
   input  wire logic [WIDTH-1:0] rise_mask_i,
   input  wire logic [WIDTH-1:0] fall_mask_i,
   // Software clears, one bit per latch bit
   input  wire logic [WIDTH-1:0] rise_clr_i,
   input  wire logic [WIDTH-1:0] fall_clr_i,
   // Latched interrupts
   output logic      [WIDTH-1:0] rise_latch_o,
   output logic      [WIDTH-1:0] fall_latch_o
);

   logic [WIDTH-1:0] prev_q, prev_d;
   logic [WIDTH-1:0] rise_q, rise_d;
   logic [WIDTH-1:0] fall_q, fall_d;

   always_comb begin
      prev_d = status_i;
      // masked rising edge
      // A new edge wins over a clear in the same cycle.
      rise_d = (rise_q & ~rise_clr_i) | (status_i & ~prev_q & rise_mask_i);
      fall_d = (fall_q & ~fall_clr_i) | (~status_i & prev_q & fall_mask_i);
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prev_q <= '0;
         rise_q <= '0;
         fall_q <= '0;
      end else begin
         prev_q <= prev_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
      end
   end

   assign rise_latch_o = rise_q;
   assign fall_latch_o = fall_q;

endmodule

// >>> rtl/sia_reg_bank.sv
// Register bank: sensor edge interrupts, clock measure, indirect access.
//
// Overview of operation
// - The masks exist per port and the port select picks the copy reached.
// - The clock measure register reads the raw frequency in MHz straight from ref_clock_measure_i, with no reset value.
// - The target select in bits 5:2 routes indirect accesses to one block, to both port blocks for a 0110 write, or to no block for a reserved code.
// - Target code 0110 sends an indirect write to both port blocks at once.
// - With auto-increment set the offset advances by one after each access.
// - With prefetch set, writing the offset issues a read strobe.
// - With prefetch and auto-increment set, a data read strobes again.
// - The offset register holds an 8-bit offset into the target block.
// - Data writes go to the target register; data reads return its value.
module sia_reg_bank #(
   parameter int NPORTS = 2,
   parameter int SWIDTH = 8
) (
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       arst_n_i,
   // Register access port from the serial control slave
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   input  wire logic [7:0]                 reg_addr_i,
   input  wire logic [7:0]                 reg_wdata_i,
   output logic      [7:0]                 reg_rdata_o,
   // Sensor status and clock measurement
   input  wire logic [NPORTS*SWIDTH-1:0]   sensor_status_word_i,
   input  wire logic [7:0]                 ref_clock_measure_i,
   // Indirect target side
   output logic      [sia_pkg::NUM_LANES-1:0] ind_wr_o,
   output logic      [sia_pkg::NUM_LANES-1:0] ind_rd_o,
   output logic      [7:0]                 indirect_offset_o,
   output logic      [7:0]                 indirect_data_o,
   input  wire logic [sia_pkg::NUM_LANES*8-1:0] ind_rdata_i
);

   // ------------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------------
   if (NPORTS < 1 || NPORTS > 4) begin : g_bad_ports
      $error("NPORTS must be 1 to 4");
   end
   if (SWIDTH != 8) begin : g_bad_width
      $error("SWIDTH must be 8 for byte registers");
   end

   // Maps a target code onto its one-hot lane set; zero for reserved codes.
   function automatic logic [sia_pkg::NUM_LANES-1:0] lanes_of(
      input logic [3:0] sel,
      input logic       is_write);
      logic [sia_pkg::NUM_LANES-1:0] l;
      l = '0;
      case (sel)
         sia_pkg::TGT_PATGEN: l[sia_pkg::LANE_PATGEN] = 1'b1;
         sia_pkg::TGT_PORT0:  l[sia_pkg::LANE_PORT0] = 1'b1;
         sia_pkg::TGT_PORT1:  l[sia_pkg::LANE_PORT1] = 1'b1;
         sia_pkg::TGT_SHARED: l[sia_pkg::LANE_SHARED] = 1'b1;
         sia_pkg::TGT_CSI:    l[sia_pkg::LANE_CSI] = 1'b1;
         sia_pkg::TGT_BOTH_PORT: begin
            // Broadcast only makes sense for writes.
            l[sia_pkg::LANE_PORT0] = is_write;
            l[sia_pkg::LANE_PORT1] = is_write;
         end
         default: l = '0;
      endcase
      return l;
   endfunction

   // ------------------------------------------------------------------
   // Direct registers
   // ------------------------------------------------------------------
   logic [1:0]        port_sel_q, port_sel_d;
   logic [7:0]        rise_mask_q [NPORTS];
   logic [7:0]        rise_mask_d [NPORTS];
   logic [7:0]        fall_mask_q [NPORTS];
   logic [7:0]        fall_mask_d [NPORTS];
   logic [7:0]        ctl_q, ctl_d;
   logic [7:0]        offset_q, offset_d;
   logic [7:0]        data_q, data_d;
   logic [7:0]        rdata_q, rdata_d;
   logic [sia_pkg::NUM_LANES-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [7:0]        rise_lat [NPORTS];
   logic [7:0]        fall_lat [NPORTS];
   logic [7:0]        rise_clr [NPORTS];
   logic [7:0]        fall_clr [NPORTS];
   logic [3:0]        sel;
   logic              autoinc, prefetch;
   logic [7:0]        sel_rdata;
   logic [sia_pkg::NUM_LANES-1:0] rd_lanes;
   int                p;

   assign p        = (int'(port_sel_q) < NPORTS) ? int'(port_sel_q) : 0;
   assign sel      = ctl_q[sia_pkg::CTL_SEL_MSB:sia_pkg::CTL_SEL_LSB];
   assign autoinc  = ctl_q[sia_pkg::CTL_AUTOINC_BIT];
   assign prefetch = ctl_q[sia_pkg::CTL_PREFETCH_BIT];
   assign rd_lanes = lanes_of(sel, 1'b0);

   // ------------------------------------------------------------------
   // Per-port edge detectors
   // ------------------------------------------------------------------
   for (genvar g = 0; g < NPORTS; g++) begin : g_port
      sia_edge_latch #(.WIDTH(SWIDTH)) u_edge (
         .clk_i       (clk_i),
         .arst_n_i    (arst_n_i),
         .status_i    (sensor_status_word_i[g*SWIDTH +: SWIDTH]),
         .rise_mask_i (rise_mask_q[g]),
         .fall_mask_i (fall_mask_q[g]),
         .rise_clr_i  (rise_clr[g]),
         .fall_clr_i  (fall_clr[g]),
         .rise_latch_o(rise_lat[g]),
         .fall_latch_o(fall_lat[g])
      );
      // Write-one-to-clear on the selected port's latch registers.
      always_comb begin
         rise_clr[g] = '0;
         fall_clr[g] = '0;
         if (reg_wr_i && p == g) begin
            if (reg_addr_i == sia_pkg::ADDR_RISE_LATCH) begin
               rise_clr[g] = reg_wdata_i;
            end
            if (reg_addr_i == sia_pkg::ADDR_FALL_LATCH) begin
               fall_clr[g] = reg_wdata_i;
            end
         end
      end
   end

   // Selected target's read data, broadcast code reads port 0.
   always_comb begin
      sel_rdata = '0;
      for (int i = 0; i < sia_pkg::NUM_LANES; i++) begin
         if (rd_lanes[i]) begin
            sel_rdata = ind_rdata_i[i*8 +: 8];
         end
      end
      if (sel == sia_pkg::TGT_BOTH_PORT) begin
         sel_rdata = ind_rdata_i[sia_pkg::LANE_PORT0*8 +: 8];
      end
   end

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      port_sel_d  = port_sel_q;
      rise_mask_d = rise_mask_q;
      fall_mask_d = fall_mask_q;
      ctl_d       = ctl_q;
      offset_d    = offset_q;
      data_d      = data_q;
      rdata_d     = rdata_q;
      wr_d        = '0;
      rd_d        = '0;
      if (reg_wr_i) begin
         case (reg_addr_i)
            sia_pkg::ADDR_PORT_SEL:
               port_sel_d = reg_wdata_i[1:0] & sia_pkg::PORT_SEL_MASK;
            sia_pkg::ADDR_RISE_MASK: rise_mask_d[p] = reg_wdata_i;
            sia_pkg::ADDR_FALL_MASK: fall_mask_d[p] = reg_wdata_i;
            sia_pkg::ADDR_IND_CTL:
               ctl_d = reg_wdata_i & sia_pkg::CTL_WRITE_MASK;
            sia_pkg::ADDR_IND_OFFSET: begin
               offset_d = reg_wdata_i;
               if (prefetch) begin
                  rd_d = lanes_of(sel, 1'b0);
               end
            end
            sia_pkg::ADDR_IND_DATA: begin
               data_d = reg_wdata_i;
               wr_d = lanes_of(sel, 1'b1);
               if (autoinc) begin
                  offset_d = offset_q + 8'h01;
               end
            end
            default: ;
         endcase
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            sia_pkg::ADDR_PORT_SEL:   rdata_d = {6'h00, port_sel_q};
            sia_pkg::ADDR_RISE_MASK:  rdata_d = rise_mask_q[p];
            sia_pkg::ADDR_FALL_MASK:  rdata_d = fall_mask_q[p];
            sia_pkg::ADDR_RISE_LATCH: rdata_d = rise_lat[p];
            sia_pkg::ADDR_FALL_LATCH: rdata_d = fall_lat[p];
            sia_pkg::ADDR_REF_CLOCK:  rdata_d = ref_clock_measure_i;
            sia_pkg::ADDR_IND_CTL:    rdata_d = ctl_q;
            sia_pkg::ADDR_IND_OFFSET: rdata_d = offset_q;
            sia_pkg::ADDR_IND_DATA: begin
               rdata_d = sel_rdata;
               if (autoinc) begin
                  offset_d = offset_q + 8'h01;
                  if (prefetch) begin
                     rd_d = lanes_of(sel, 1'b0);
                  end
               end
            end
            default: rdata_d = sia_pkg::RST_BYTE;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         port_sel_q <= '0;
         for (int i = 0; i < NPORTS; i++) begin
            rise_mask_q[i] <= sia_pkg::RST_BYTE;
            fall_mask_q[i] <= sia_pkg::RST_BYTE;
         end
         ctl_q    <= sia_pkg::RST_BYTE;
         offset_q <= sia_pkg::RST_BYTE;
         data_q   <= sia_pkg::RST_BYTE;
         rdata_q  <= sia_pkg::RST_BYTE;
         wr_q     <= '0;
         rd_q     <= '0;
      end else begin
         port_sel_q  <= port_sel_d;
         rise_mask_q <= rise_mask_d;
         fall_mask_q <= fall_mask_d;
         ctl_q       <= ctl_d;
         offset_q    <= offset_d;
         data_q      <= data_d;
         rdata_q     <= rdata_d;
         wr_q        <= wr_d;
         rd_q        <= rd_d;
      end
   end

   // Offset and data outputs line up with the strobes: the strobe and the
   // offset it addresses leave their flops on the same edge, and the
   // incremented offset moves on the same edge that raises the read strobe,
   // so a prefetch on a data read addresses the next location.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         indirect_offset_o <= sia_pkg::RST_BYTE;
      end else begin
         indirect_offset_o <= offset_d;
      end
   end

   assign reg_rdata_o     = rdata_q;
   assign ind_wr_o        = wr_q;
   assign ind_rd_o        = rd_q;
   assign indirect_data_o = data_q;

endmodule

// >>> test/sia_target_model.sv
// Behavioural model of the indirect target blocks behind the bank.
module sia_target_model (
   // Offset presented by the bank
   input  wire logic [7:0]  offset_i,
   // Read data of each target lane
   output logic      [39:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // live lane data
   // Every lane answers at once; data differs per lane and per offset.
   for (genvar g = 0; g < 5; g++) begin : g_lane
      assign rdata_o[g*8 +: 8] = offset_i ^ 8'(8'h35 * (g + 1));
   end
endmodule

// >>> test/sia_reg_bank_checker.sv
// Concurrent checks on the hub register bank's ports.
module sia_reg_bank_checker #(
   parameter int NPORTS = 2,
   parameter int SWIDTH = 8
) (
   // Clock, reset and register port
   input wire logic        clk_i,
   input wire logic        arst_n_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [7:0]  reg_addr_i,
   input wire logic [7:0]  reg_wdata_i,
   input wire logic [7:0]  reg_rdata_o,
   input wire logic [7:0]  ref_clock_measure_i,
   // Indirect target side
   input wire logic [4:0]  ind_wr_o,
   input wire logic [4:0]  ind_rd_o,
   input wire logic [7:0]  indirect_offset_o,
   input wire logic [39:0] ind_rdata_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ctl_q;
   logic [3:0] sel;
   logic [4:0] wl;
   logic [4:0] rl;
   logic [7:0] tgt_now;
   logic       rd_ok;
   logic       wr_dat;
   logic       rd_dat;
   logic       rd_trig;
   // Shadow of the control register, so no peeking inside the design.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctl_q <= 8'h00;
      end else if (reg_wr_i && reg_addr_i == sia_pkg::ADDR_IND_CTL) begin
         ctl_q <= reg_wdata_i & sia_pkg::CTL_WRITE_MASK;
      end
   end
   assign sel = ctl_q[5:2];
   assign wl = sel == 4'h0 ? 5'h01 : sel == 4'h1 ? 5'h02 : sel == 4'h2 ? 5'h04
             : sel == 4'h5 ? 5'h08 : sel == 4'h6 ? 5'h06 : sel == 4'h7 ? 5'h10
             : 5'h00;
   assign rl = sel == 4'h6 ? 5'h00 : wl;
   assign tgt_now = wl[0] ? ind_rdata_i[7:0] : wl[1] ? ind_rdata_i[15:8]
                  : wl[2] ? ind_rdata_i[23:16] : wl[3] ? ind_rdata_i[31:24]
                  : ind_rdata_i[39:32];
   assign rd_ok = reg_rd_i && !reg_wr_i;
   assign wr_dat = reg_wr_i && reg_addr_i == sia_pkg::ADDR_IND_DATA;
   assign rd_dat = rd_ok && reg_addr_i == sia_pkg::ADDR_IND_DATA;
   assign rd_trig = (reg_wr_i && reg_addr_i == sia_pkg::ADDR_IND_OFFSET
                     && ctl_q[0]) || (rd_dat && ctl_q[1:0] == 2'h3);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   property p_ctl_read; rd_ok && reg_addr_i == sia_pkg::ADDR_IND_CTL
      |=> reg_rdata_o == $past(ctl_q); endproperty
   a_ctl_read: assert property (p_ctl_read) else $error("ctl read");
   property p_ref; rd_ok && reg_addr_i == sia_pkg::ADDR_REF_CLOCK
      |=> reg_rdata_o == $past(ref_clock_measure_i); endproperty
   a_ref: assert property (p_ref) else $error("clock measure read");
   property p_off_wr; reg_wr_i && reg_addr_i == sia_pkg::ADDR_IND_OFFSET
      |=> indirect_offset_o == $past(reg_wdata_i); endproperty
   a_off_wr: assert property (p_off_wr) else $error("offset write");
   property p_wr_lane; wr_dat |=> ind_wr_o == $past(wl); endproperty
   a_wr_lane: assert property (p_wr_lane) else $error("wr lanes");
   property p_rd_lane; rd_trig |=> ind_rd_o == $past(rl); endproperty
   a_rd_lane: assert property (p_rd_lane) else $error("rd lanes");
   property p_rd_idle; !rd_trig |=> ind_rd_o == 5'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read");
   property p_inc; (wr_dat || rd_dat) && ctl_q[1] && wl != 5'h00
      |=> indirect_offset_o == $past(indirect_offset_o) + 8'h01; endproperty
   a_inc: assert property (p_inc) else $error("auto increment");
   property p_rdata; rd_dat && wl != 5'h00
      |=> reg_rdata_o == $past(tgt_now); endproperty
   a_rdata: assert property (p_rdata) else $error("data read");
   c_both: cover property (wr_dat && sel == 4'h6);
   c_pref: cover property (rd_trig && ctl_q[1:0] == 2'h3);
   c_rsvd: cover property (wr_dat && wl == 5'h00);
endmodule

// >>> test/sia_reg_bank_tb.sv
// Self-checking bench of the hub register bank.
module sia_reg_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0;
   logic        arst_n_i = 1'b0;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic [15:0] sensor_status_word_i;
   logic [7:0]  ref_clock_measure_i;
   logic [7:0]  reg_rdata_o;
   logic [4:0]  ind_wr_o;
   logic [4:0]  ind_rd_o;
   logic [7:0]  indirect_offset_o;
   logic [7:0]  indirect_data_o;
   logic [39:0] ind_rdata_i;
   logic [7:0]  exp_q[$];
   logic        rd_pend = 1'b0;
   logic [7:0]  exp_d[$];
   logic        wr_pend = 1'b0;
   int          fails = 0;
   int          n_tests = 0;
   int          cyc = 0;
   sia_reg_bank #(.NPORTS(2), .SWIDTH(8)) i_dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .sensor_status_word_i(sensor_status_word_i),
      .ref_clock_measure_i(ref_clock_measure_i), .ind_wr_o(ind_wr_o),
      .ind_rd_o(ind_rd_o), .indirect_offset_o(indirect_offset_o),
      .indirect_data_o(indirect_data_o), .ind_rdata_i(ind_rdata_i));
   sia_target_model i_tgt (.offset_i(indirect_offset_o), .rdata_o(ind_rdata_i));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   // Each call holds the request for exactly one edge, so reads and
   // writes may follow back to back without a signal changing twice.
   task automatic bus(input logic w, r, input logic [7:0] a, d);
      @(posedge clk_i);
      reg_wr_i    <= w;
      reg_rd_i    <= r;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
   endtask
   task automatic rd(input logic [7:0] a, e);
      bus(1'b0, 1'b1, a, 8'h00);
      exp_q.push_back(e);
   endtask
   task automatic check_byte(input logic [7:0] e, g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("wrong value reg_rdata_o expected %h seen %h", e, g);
      end
   endtask
   task automatic check_data(input logic [7:0] e, g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("wrong value indirect_data_o expected %h seen %h", e, g);
      end
   endtask
   task automatic give_verdict();
      if (fails == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   function automatic logic [7:0] tgt(input int l, input logic [7:0] o);
      return o ^ 8'(8'h35 * (l + 1));
   endfunction
   always @(posedge clk_i) rd_pend <= reg_rd_i && !reg_wr_i;
   always @(posedge clk_i) begin
      wr_pend <= reg_wr_i && reg_addr_i == sia_pkg::ADDR_IND_DATA;
   end
   // Read data is registered, so it is settled by the following low phase.
   always @(negedge clk_i) begin
      if (rd_pend) begin
         check_byte(exp_q.pop_front(), reg_rdata_o);
      end
      if (wr_pend) begin
         check_data(exp_d.pop_front(), indirect_data_o);
      end
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         give_verdict();
      end
   end
   initial begin
      logic [7:0]  mr[2];
      logic [7:0]  mf[2];
      logic [7:0]  rc;
      logic [7:0]  o;
      logic [15:0] s0;
      logic [15:0] x;
      logic        ai;
      logic [7:0]  w;
      logic [7:0]  rst_a[7] = '{8'h7e, 8'h7f, 8'h80, 8'h81, 8'hb0, 8'hb1, 8'hb4};
      logic [3:0]  codes[8] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h3, 4'hc};
      int          lane[6] = '{0, 1, 2, 3, 1, 4};
      void'($urandom(32'ha054));
      s0 = 16'($urandom);
      rc = 8'($urandom);
      sensor_status_word_i = s0;
      ref_clock_measure_i = rc;
      repeat (10) @(posedge clk_i);
      arst_n_i <= 1'b1;
      foreach (rst_a[i]) rd(rst_a[i], 8'h00);
      rd(sia_pkg::ADDR_REF_CLOCK, rc);
      rd(sia_pkg::ADDR_REF_CLOCK, rc);
      for (int p = 0; p < 2; p++) begin
         mr[p] = 8'($urandom);
         mf[p] = 8'($urandom);
         bus(1'b1, 1'b0, sia_pkg::ADDR_PORT_SEL, 8'(p));
         bus(1'b1, 1'b0, sia_pkg::ADDR_RISE_MASK, mr[p]);
         bus(1'b1, 1'b0, sia_pkg::ADDR_FALL_MASK, mf[p]);
      end
      // Each toggled bit makes one rising and one falling edge.
      x = 16'($urandom);
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      sensor_status_word_i <= s0 ^ x;
      repeat (2) bus(1'b0, 1'b0, 8'h00, 8'h00);
      sensor_status_word_i <= s0;
      repeat (2) bus(1'b0, 1'b0, 8'h00, 8'h00);
      for (int p = 0; p < 2; p++) begin
         bus(1'b1, 1'b0, sia_pkg::ADDR_PORT_SEL, 8'(p));
         rd(sia_pkg::ADDR_RISE_MASK, mr[p]);
         rd(sia_pkg::ADDR_FALL_MASK, mf[p]);
         rd(sia_pkg::ADDR_RISE_LATCH, x[p*8 +: 8] & mr[p]);
         rd(sia_pkg::ADDR_FALL_LATCH, x[p*8 +: 8] & mf[p]);
         bus(1'b1, 1'b0, sia_pkg::ADDR_RISE_LATCH, 8'hff);
         bus(1'b1, 1'b0, sia_pkg::ADDR_FALL_LATCH, 8'hff);
         rd(sia_pkg::ADDR_RISE_LATCH, 8'h00);
         rd(sia_pkg::ADDR_FALL_LATCH, 8'h00);
      end
      foreach (codes[i]) begin
         ai = i[0];
         o = 8'($urandom);
         w = 8'($urandom);
         bus(1'b1, 1'b0, sia_pkg::ADDR_IND_CTL, {2'h3, codes[i], ai, ai});
         rd(sia_pkg::ADDR_IND_CTL, {2'h0, codes[i], ai, ai});
         bus(1'b1, 1'b0, sia_pkg::ADDR_IND_OFFSET, o);
         if (i < 6) begin
            rd(sia_pkg::ADDR_IND_DATA, tgt(lane[i], o));
            rd(sia_pkg::ADDR_IND_DATA, tgt(lane[i], o + 8'(ai)));
         end
         bus(1'b1, 1'b0, sia_pkg::ADDR_IND_DATA, w);
         exp_d.push_back(w);
         if (i < 6) begin
            rd(sia_pkg::ADDR_IND_OFFSET, o + (ai ? 8'h03 : 8'h00));
         end
      end
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      repeat (3) @(posedge clk_i);
      give_verdict();
   end
endmodule
bind sia_reg_bank sia_reg_bank_checker #(.NPORTS(NPORTS), .SWIDTH(SWIDTH))
   i_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .ref_clock_measure_i(ref_clock_measure_i),
   .ind_wr_o(ind_wr_o), .ind_rd_o(ind_rd_o),
   .indirect_offset_o(indirect_offset_o), .ind_rdata_i(ind_rdata_i));
